// [fpc_pkg.sv]
/*
 * Shared constants and types of the five-pin communications port.
 * Assumes a 125 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package fpc_pkg;
    localparam int CLK_MHZ = 125;

    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TXDATA = 8'h08;
    localparam logic [7:0] ADDR_RXDATA = 8'h0c;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_HYST_LSB = 4;
    localparam int CTRL_FILT_LSB = 8;
    localparam int CTRL_FOFF_BIT = 10;
    localparam int CTRL_SLEEP_BIT = 12;
    localparam int CTRL_WAKE_BIT = 13;
    localparam logic [31:0] CTRL_MASK = 32'h00003773;
    localparam logic [31:0] CTRL_RESET = 32'h00000000;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_RXV_BIT = 1;

    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // Suppression times in ns; cycle counts round up to whole mclk periods.
    localparam int GLITCH0_NS = 75;
    localparam int GLITCH1_NS = 410;
    localparam int GLITCH2_NS = 800;
    localparam int GLITCH3_NS = 1500;
    localparam logic [7:0] GLITCH0_CYC = 8'((GLITCH0_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] GLITCH1_CYC = 8'((GLITCH1_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] GLITCH2_CYC = 8'((GLITCH2_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] GLITCH3_CYC = 8'((GLITCH3_NS * CLK_MHZ + 999) / 1000);

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_SPECIAL = 2'h1,
        MODE_DIFF = 2'h2
    } fpc_mode_type;

    typedef enum logic [1:0] {
        TX_IDLE = 2'h1,
        TX_SEND = 2'h2
    } fpc_tx_state_type;

    typedef enum logic [1:0] {
        RX_IDLE = 2'h1,
        RX_CELL = 2'h2
    } fpc_rx_state_type;

    function automatic logic [7:0] glitch_limit(input logic [1:0] code);
        case (code)
            2'h0: glitch_limit = GLITCH0_CYC;
            2'h1: glitch_limit = GLITCH1_CYC;
            2'h2: glitch_limit = GLITCH2_CYC;
            default: glitch_limit = GLITCH3_CYC;
        endcase
    endfunction : glitch_limit
endpackage : fpc_pkg

// [fpc_glitch_filter.sv]
/*
 * Receive glitch filter: the output follows the input only after the
 * input has held a new level for the selected number of clock cycles.
 * Assumes lineIn is already synchronised to clk.
 */
module fpc_glitch_filter (
    input wire logic clk,
    input wire logic rstN,
    input wire logic lineIn,
    input wire logic [1:0] code,
    input wire logic bypass,
    output logic lineOut
);
    logic [7:0] cnt;
    logic [7:0] limit;

    assign limit = fpc_pkg::glitch_limit(code);

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            cnt <= 8'h00;
            lineOut <= 1'b0;
        end else if (bypass) begin
            cnt <= 8'h00;
            lineOut <= lineIn;
        end else if (lineIn == lineOut) begin
            cnt <= 8'h00;
        end else if (cnt >= limit - 8'h01) begin // [R09]
            cnt <= 8'h00;
            lineOut <= lineIn;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end

    glitch_hold_a: assert property (@(posedge clk) disable iff (!rstN) // [R09]
        (!bypass && !$past(bypass) && $changed(lineOut)) |-> ($past(cnt) >= $past(limit) - 8'h01))
        else $error("filter output moved before the input was stable long enough");
endmodule : fpc_glitch_filter

// [fpc_comm_port.sv]
/*
 * Five-pin communications port: AHB-Lite registers on mclk, line coding
 * and pin drive on the link clock, receive glitch filter on mclk.
 * Assumes linkClk runs freely; one link cycle is half a bit cell.
 */
// Functional notes
// [R01] Port runs in exactly one of three modes: single-ended, special, differential.
// [R02] Single-ended: receive and transmit pins carry data, third pin enables transceiver.
// [R03] Single-ended and differential modes use Differential Manchester coding both ways.
// [R04] Special mode drives a bit clock and a frame clock to the transceiver.
// [R05] Special mode sends and takes raw bits; the transceiver does the coding.
// [R06] Differential mode: receive and transmit pins form one filtered receive pair.
// [R07] Differential mode drives data as a complementary pair on two pins.
// [R08] Hysteresis code 0 to 7 is taken from software and passed on.
// [R09] Glitch filter code 0 to 3 suppresses ever longer pulses.
// [R10] Software must switch the glitch filter off at high data rates.
// [R11] Differential receiver is on when awake, or asleep with wake-up unmasked.
// [R12] Every cell boundary toggles; a mid-cell toggle marks a zero.
module fpc_comm_port (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic linkClk,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic commPinReceiveIn,
    input wire logic commPinTransmitIn,
    output logic commPinTransmitOut,
    output logic commPinTransmitOe,
    output logic commPinEnableOrBitclkOut,
    output logic commPinEnableOrBitclkOe,
    output logic commPinDriveNegOut,
    output logic commPinDriveNegOe,
    output logic commPinFrameClockOut,
    output logic commPinFrameClockOe,
    output logic diffRxEnable,
    output logic [2:0] diffHysteresis
);
    logic rstMeta;
    logic rstN;
    logic addrAcc;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] ctrl;
    logic [31:0] next_ctrl;
    logic modeLegal;
    logic [7:0] txHold;
    logic txReq;
    logic ackS1;
    logic ackS2;
    logic txBusy;
    logic rxTogS1;
    logic rxTogS2;
    logic rxTogS3;
    logic [7:0] rxData;
    logic rxValid;
    logic rcvS1;
    logic rcvS2;
    logic trnS1;
    logic trnS2;
    logic diffLine;
    logic rawLine;
    logic rxFilt;
    logic txAck;
    logic [7:0] rxHold;
    logic rxTog;
    fpc_pkg::fpc_mode_type mode;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rstMeta <= 1'b0;
            rstN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstN <= rstMeta;
        end
    end

    // The slave never stalls, so every transfer completes with zero waits.
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign addrAcc = hsel && hready && htrans[1];

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else begin
            wrPend <= addrAcc && hwrite && (hsize == fpc_pkg::HSIZE_WORD);
            wrAddr <= haddr[7:0];
        end
    end

    assign mode = fpc_pkg::fpc_mode_type'(ctrl[fpc_pkg::CTRL_MODE_LSB +: 2]);
    assign modeLegal = (hwdata[fpc_pkg::CTRL_MODE_LSB +: 2] != 2'h3); // [R01]

    // A write with the unused mode code is dropped whole, so the port always
    // stays in one of the three defined modes.
    always_comb begin
        next_ctrl = ctrl;
        if (wrPend && wrAddr == fpc_pkg::ADDR_CTRL && modeLegal) begin // [R01]
            next_ctrl = hwdata & fpc_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ctrl <= fpc_pkg::CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign diffHysteresis = ctrl[fpc_pkg::CTRL_HYST_LSB +: 3]; // [R08]

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            diffRxEnable <= 1'b0;
        end else begin
            diffRxEnable <= (mode == fpc_pkg::MODE_DIFF) && // [R11]
                (!ctrl[fpc_pkg::CTRL_SLEEP_BIT] || ctrl[fpc_pkg::CTRL_WAKE_BIT]);
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ackS1 <= 1'b0;
            ackS2 <= 1'b0;
            rxTogS1 <= 1'b0;
            rxTogS2 <= 1'b0;
            rxTogS3 <= 1'b0;
        end else begin
            ackS1 <= txAck;
            ackS2 <= ackS1;
            rxTogS1 <= rxTog;
            rxTogS2 <= rxTogS1;
            rxTogS3 <= rxTogS2;
        end
    end

    assign txBusy = (txReq != ackS2);

    // A byte written while the previous one is in flight is ignored.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            txHold <= 8'h00;
            txReq <= 1'b0;
        end else if (wrPend && wrAddr == fpc_pkg::ADDR_TXDATA && !txBusy) begin
            txHold <= hwdata[7:0];
            txReq <= ~txReq;
        end
    end

    // A new byte arriving in the cycle of a data read keeps the flag set.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rxData <= 8'h00;
            rxValid <= 1'b0;
        end else if (rxTogS2 != rxTogS3) begin
            rxData <= rxHold;
            rxValid <= 1'b1;
        end else if (addrAcc && !hwrite && haddr[7:0] == fpc_pkg::ADDR_RXDATA) begin
            rxValid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            hrdata <= 32'h00000000;
        end else if (addrAcc && !hwrite) begin
            case (haddr[7:0])
                fpc_pkg::ADDR_CTRL: hrdata <= next_ctrl;
                fpc_pkg::ADDR_STATUS: hrdata <= {30'h00000000, rxValid, txBusy};
                fpc_pkg::ADDR_TXDATA: hrdata <= {24'h000000, txHold};
                fpc_pkg::ADDR_RXDATA: hrdata <= {24'h000000, rxData};
                default: hrdata <= 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            rcvS1 <= 1'b0;
            rcvS2 <= 1'b0;
            trnS1 <= 1'b0;
            trnS2 <= 1'b0;
        end else begin
            rcvS1 <= commPinReceiveIn;
            rcvS2 <= rcvS1;
            trnS1 <= commPinTransmitIn;
            trnS2 <= trnS1;
        end
    end

    // Digital view of the pair: a level counts only when the two pins
    // disagree, so a common-mode excursion leaves the last level standing.
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            diffLine <= 1'b0;
        end else if (diffRxEnable && rcvS2 != trnS2) begin // [R06]
            diffLine <= rcvS2;
        end
    end

    assign rawLine = (mode == fpc_pkg::MODE_DIFF) ? diffLine : rcvS2; // [R06]

    fpc_glitch_filter filter (
        .clk(mclk),
        .rstN(rstN),
        .lineIn(rawLine),
        .code(ctrl[fpc_pkg::CTRL_FILT_LSB +: 2]),
        .bypass(ctrl[fpc_pkg::CTRL_FOFF_BIT]), // [R10]
        .lineOut(rxFilt)
    );

    logic lrMeta;
    logic lrN;
    logic [1:0] modeS1;
    logic [1:0] modeS2;
    logic reqS1;
    logic reqS2;
    logic reqS3;
    logic lineS1;
    logic lineS2;
    logic linePrev;
    fpc_pkg::fpc_mode_type linkMode;
    logic coded;
    logic sending;
    fpc_pkg::fpc_tx_state_type txState;
    fpc_pkg::fpc_rx_state_type rxState;
    logic ph;
    logic [2:0] bitCnt;
    logic [7:0] txShift;
    logic txLine;
    logic bitClk;
    logic frame;
    logic rPh;
    logic rH1;
    logic [2:0] rCnt;
    logic [7:0] rxShift;
    logic [3:0] spTake;
    logic [3:0] spLast;

    always_ff @(posedge linkClk or negedge rstN) begin
        if (!rstN) begin
            lrMeta <= 1'b0;
            lrN <= 1'b0;
        end else begin
            lrMeta <= 1'b1;
            lrN <= lrMeta;
        end
    end

    // Mode is quasi-static; changing it mid-frame corrupts that frame.
    always_ff @(posedge linkClk or negedge lrN) begin
        if (!lrN) begin
            modeS1 <= 2'h0;
            modeS2 <= 2'h0;
            reqS1 <= 1'b0;
            reqS2 <= 1'b0;
            reqS3 <= 1'b0;
            lineS1 <= 1'b0;
            lineS2 <= 1'b0;
            linePrev <= 1'b0;
        end else begin
            modeS1 <= ctrl[fpc_pkg::CTRL_MODE_LSB +: 2];
            modeS2 <= modeS1;
            reqS1 <= txReq;
            reqS2 <= reqS1;
            reqS3 <= reqS2;
            lineS1 <= rxFilt;
            lineS2 <= lineS1;
            linePrev <= lineS2;
        end
    end

    assign linkMode = fpc_pkg::fpc_mode_type'(modeS2);
    assign coded = (linkMode != fpc_pkg::MODE_SPECIAL); // [R03]
    assign sending = (txState == fpc_pkg::TX_SEND);

    always_ff @(posedge linkClk or negedge lrN) begin
        if (!lrN) begin
            txState <= fpc_pkg::TX_IDLE;
            ph <= 1'b0;
            bitCnt <= 3'h0;
            txShift <= 8'h00;
            txLine <= 1'b0;
            bitClk <= 1'b0;
            frame <= 1'b0;
            txAck <= 1'b0;
        end else begin
            case (txState)
                fpc_pkg::TX_IDLE: begin
                    ph <= 1'b0;
                    bitCnt <= 3'h0;
                    bitClk <= 1'b0;
                    frame <= 1'b0;
                    if (reqS2 != reqS3) begin
                        txShift <= txHold;
                        txState <= fpc_pkg::TX_SEND;
                    end
                end
                fpc_pkg::TX_SEND: begin
                    ph <= ~ph;
                    bitClk <= ~ph; // [R04]
                    if (!ph) begin
                        frame <= (bitCnt == 3'h0); // [R04]
                    end
                    if (coded) begin
                        if (!ph || !txShift[0]) begin // [R03] [R12]
                            txLine <= ~txLine;
                        end
                    end else if (!ph) begin
                        txLine <= txShift[0]; // [R05]
                    end
                    if (ph) begin
                        txShift <= {1'b0, txShift[7:1]};
                        bitCnt <= bitCnt + 3'h1;
                        if (bitCnt == fpc_pkg::BIT_LAST) begin
                            txAck <= reqS3;
                            txState <= fpc_pkg::TX_IDLE;
                        end
                    end
                end
                default: txState <= fpc_pkg::TX_IDLE;
            endcase
        end
    end

    // Special-mode data comes back through the pin register, the transceiver
    // and the receive synchronisers, so each cell is taken four link cycles
    // after its own second half, in the second half of the returned bit.
    always_ff @(posedge linkClk or negedge lrN) begin
        if (!lrN) begin
            spTake <= 4'h0;
            spLast <= 4'h0;
        end else begin
            spTake <= {spTake[2:0], sending && ph && !coded};
            spLast <= {spLast[2:0], sending && ph && !coded && bitCnt == fpc_pkg::BIT_LAST};
        end
    end

    // Coded receive finds the first edge of a frame, which is a cell
    // boundary, then compares the two halves of each cell.
    always_ff @(posedge linkClk or negedge lrN) begin
        if (!lrN) begin
            rxState <= fpc_pkg::RX_IDLE;
            rPh <= 1'b0;
            rH1 <= 1'b0;
            rCnt <= 3'h0;
            rxShift <= 8'h00;
            rxHold <= 8'h00;
            rxTog <= 1'b0;
        end else if (!coded) begin
            rxState <= fpc_pkg::RX_IDLE;
            if (spTake[3]) begin // [R05]
                rxShift <= {lineS2, rxShift[7:1]};
                if (spLast[3]) begin
                    rxHold <= {lineS2, rxShift[7:1]};
                    rxTog <= ~rxTog;
                end
            end
        end else begin
            case (rxState)
                fpc_pkg::RX_IDLE: begin
                    rCnt <= 3'h0;
                    if (lineS2 != linePrev) begin
                        rH1 <= lineS2;
                        rPh <= 1'b1;
                        rxState <= fpc_pkg::RX_CELL;
                    end
                end
                fpc_pkg::RX_CELL: begin
                    rPh <= ~rPh;
                    if (!rPh) begin
                        rH1 <= lineS2;
                    end else begin
                        rxShift <= {rH1 == lineS2, rxShift[7:1]}; // [R03] [R12]
                        rCnt <= rCnt + 3'h1;
                        if (rCnt == fpc_pkg::BIT_LAST) begin
                            rxHold <= {rH1 == lineS2, rxShift[7:1]};
                            rxTog <= ~rxTog;
                            rxState <= fpc_pkg::RX_IDLE;
                        end
                    end
                end
                default: rxState <= fpc_pkg::RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge linkClk or negedge lrN) begin
        if (!lrN) begin
            commPinTransmitOut <= 1'b0;
            commPinTransmitOe <= 1'b0;
            commPinEnableOrBitclkOut <= 1'b0;
            commPinEnableOrBitclkOe <= 1'b0;
            commPinDriveNegOut <= 1'b0;
            commPinDriveNegOe <= 1'b0;
            commPinFrameClockOut <= 1'b0;
            commPinFrameClockOe <= 1'b0;
        end else begin
            commPinTransmitOut <= txLine;
            commPinTransmitOe <= 1'b1;
            commPinDriveNegOut <= 1'b0;
            commPinDriveNegOe <= 1'b0;
            commPinFrameClockOut <= 1'b0;
            commPinFrameClockOe <= 1'b0;
            case (linkMode) // [R01]
                fpc_pkg::MODE_SPECIAL: begin
                    commPinEnableOrBitclkOut <= bitClk; // [R04]
                    commPinEnableOrBitclkOe <= 1'b1;
                    commPinFrameClockOut <= frame; // [R04]
                    commPinFrameClockOe <= 1'b1;
                end
                fpc_pkg::MODE_DIFF: begin
                    commPinTransmitOe <= 1'b0; // [R06]
                    commPinEnableOrBitclkOut <= txLine; // [R07]
                    commPinEnableOrBitclkOe <= sending;
                    commPinDriveNegOut <= ~txLine; // [R07]
                    commPinDriveNegOe <= sending;
                end
                default: begin
                    commPinEnableOrBitclkOut <= sending; // [R02]
                    commPinEnableOrBitclkOe <= 1'b1;
                end
            endcase
        end
    end

    sequence ctrl_wr_s;
        wrPend && wrAddr == fpc_pkg::ADDR_CTRL;
    endsequence

    sequence sp_half_s;
        sending && !coded && !ph;
    endsequence

    mode_legal_a: assert property (@(posedge mclk) disable iff (!rstN) // [R01]
        (ctrl_wr_s and !modeLegal) |=> $stable(ctrl))
        else $error("illegal mode code changed the control register");
    hyst_pass_a: assert property (@(posedge mclk) disable iff (!rstN) // [R08]
        (ctrl_wr_s and modeLegal) |=> diffHysteresis == $past(hwdata[fpc_pkg::CTRL_HYST_LSB +: 3]))
        else $error("hysteresis code not passed through");
    rx_enable_a: assert property (@(posedge mclk) disable iff (!rstN) // [R11]
        1'b1 |=> diffRxEnable == ($past(mode) == fpc_pkg::MODE_DIFF &&
            (!$past(ctrl[fpc_pkg::CTRL_SLEEP_BIT]) || $past(ctrl[fpc_pkg::CTRL_WAKE_BIT])))
    ) else $error("differential receiver enable wrong");
    se_enable_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R02]
        (linkMode == fpc_pkg::MODE_SINGLE)[*2] |-> commPinEnableOrBitclkOut == $past(sending))
        else $error("transceiver enable does not follow transmission");
    dm_mid_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R03]
        (sending && coded && ph) |=> $changed(txLine) == !$past(txShift[0]))
        else $error("mid-cell transition does not match the bit");
    dm_boundary_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R12]
        (sending && coded && !ph) |=> $changed(txLine))
        else $error("missing cell boundary transition");
    sp_clocks_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R04]
        sp_half_s ##1 (sending && ph) |=> !bitClk ##1 commPinEnableOrBitclkOut == 1'b0)
        else $error("bit clock does not follow the cell");
    sp_raw_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R05]
        sp_half_s |=> txLine == $past(txShift[0]))
        else $error("special mode data is not sent raw");
    diff_input_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R06]
        (linkMode == fpc_pkg::MODE_DIFF)[*2] |-> !commPinTransmitOe)
        else $error("transmit pin driven while it is a receive input");
    diff_pair_a: assert property (@(posedge linkClk) disable iff (!lrN) // [R07]
        (linkMode == fpc_pkg::MODE_DIFF)[*2] |-> commPinDriveNegOut == !commPinEnableOrBitclkOut)
        else $error("driver pair is not complementary");
endmodule : fpc_comm_port

// [fpc_xcvr_model.sv]
/*
 * Partner transceiver model: sends coded or raw bytes to the port and
 * decodes coded bytes from it. Assumes a free-running link clock.
 */
module fpc_xcvr_model (
    input wire logic linkClk,
    input wire logic txLine,
    input wire logic bitClk,
    input wire logic frameClk,
    output logic rxLine
);
    timeunit 1ns;
    timeprecision 100ps;
    initial rxLine = 1'b0;

    task automatic sendCoded(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            @(posedge linkClk) rxLine <= ~rxLine;
            @(posedge linkClk) rxLine <= b[i] ? rxLine : ~rxLine;
        end
    endtask : sendCoded

    // The first edge after idle is taken as the first cell boundary.
    task automatic recvCoded(output logic [7:0] b);
        logic a;
        @(txLine);
        for (int i = 0; i < 8; i++) begin
            @(negedge linkClk) a = txLine;
            @(negedge linkClk) b[i] = (a == txLine);
        end
    endtask : recvCoded

    // Raw bits change with the bit clock; the line is left inverted after the frame.
    task automatic sendRaw(input logic [7:0] b);
        @(posedge frameClk);
        for (int i = 0; i < 8; i++) begin
            if (i > 0) @(posedge bitClk);
            rxLine <= b[i];
        end
        repeat (2) @(posedge linkClk);
        rxLine <= ~b[7];
    endtask : sendRaw
endmodule : fpc_xcvr_model

// [test_five_pin_network_comm_port.sv]
/*
 * Testbench of the five-pin port: register tasks over AHB-Lite and a
 * partner transceiver model on the pins. Assumes the package, the port
 * and the model are compiled first.
 */
module test_five_pin_network_comm_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic linkClk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel, hwrite, hreadyout, hresp, rxLine, modeDiff;
    logic [31:0] haddr, hwdata, hrdata, rdv;
    logic [1:0] htrans;
    logic [2:0] hsize, diffHysteresis;
    logic [7:0] got, hi, lo;
    logic txOut, txOe, ebOut, ebOe, negOut, negOe, frOut, frOe, diffRxEnable;
    int fails = 0;
    int checkCount = 0;
    wire logic txWire = txOe ? txOut : ~rxLine;
    wire logic modelTx = modeDiff ? ebOut : txOut;

    fpc_comm_port dut (.mclk(mclk), .reset_n(reset_n), .linkClk(linkClk), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .commPinReceiveIn(rxLine),
        .commPinTransmitIn(txWire), .commPinTransmitOut(txOut), .commPinTransmitOe(txOe),
        .commPinEnableOrBitclkOut(ebOut), .commPinEnableOrBitclkOe(ebOe), .commPinDriveNegOut(negOut),
        .commPinDriveNegOe(negOe), .commPinFrameClockOut(frOut), .commPinFrameClockOe(frOe),
        .diffRxEnable(diffRxEnable), .diffHysteresis(diffHysteresis));
    fpc_xcvr_model xcvr (.linkClk(linkClk), .txLine(modelTx), .bitClk(ebOut), .frameClk(frOut),
        .rxLine(rxLine));

    initial forever #4 mclk = ~mclk;
    initial begin
        #3;
        forever #40 linkClk = ~linkClk;
    end

    task automatic summarize();
        $display("Checks %0d, mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : summarize

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge mclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        hsize <= fpc_pkg::HSIZE_WORD;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge mclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        check("hresp", hresp, 32'h0);
    endtask : ahb

    task automatic setCtrl(input logic [31:0] v);
        ahb(1'b1, fpc_pkg::ADDR_CTRL, v);
        repeat (4) @(posedge linkClk);
    endtask : setCtrl

    task automatic waitIdle();
        for (int i = 0; i < 40; i++) begin
            ahb(1'b0, fpc_pkg::ADDR_STATUS, 32'h0);
            if (rdv[fpc_pkg::STAT_BUSY_BIT] === 1'b0) break;
        end
        check("busy", rdv[fpc_pkg::STAT_BUSY_BIT], 32'h0);
    endtask : waitIdle

    task automatic rxCheck(input logic [7:0] b);
        for (int i = 0; i < 100; i++) begin
            ahb(1'b0, fpc_pkg::ADDR_STATUS, 32'h0);
            if (rdv[fpc_pkg::STAT_RXV_BIT] === 1'b1) break;
        end
        check("rx ready", rdv[fpc_pkg::STAT_RXV_BIT], 32'h1);
        ahb(1'b0, fpc_pkg::ADDR_RXDATA, 32'h0);
        check("rx byte", rdv, {24'h0, b});
        ahb(1'b0, fpc_pkg::ADDR_STATUS, 32'h0);
        check("rx valid", rdv[fpc_pkg::STAT_RXV_BIT], 32'h0);
    endtask : rxCheck

    task automatic txCoded(input logic [7:0] b);
        fork
            xcvr.recvCoded(got);
            ahb(1'b1, fpc_pkg::ADDR_TXDATA, {24'h0, b});
            begin
                @(negedge linkClk iff (ebOe && (modeDiff || ebOut)));
                repeat (3) @(negedge linkClk);
                if (modeDiff) check("diff pair", {negOe, negOut ^ ebOut, txOe}, 32'h6);
                else check("tx enable", {txOe, ebOut}, 32'h3);
            end
        join
        check("tx byte", got, {24'h0, b});
        waitIdle();
    endtask : txCoded

    initial begin
        #200us;
        fails++;
        summarize();
    end

    initial begin
        {hsel, hwrite, htrans, haddr, hsize, hwdata, modeDiff} = '0;
        repeat (3) @(posedge linkClk);
        @(posedge mclk) reset_n <= 1'b1;
        repeat (6) @(posedge linkClk);
        check("pin oe", {txOe, ebOe, negOe, frOe}, 32'hc);
        ahb(1'b0, fpc_pkg::ADDR_CTRL, 32'h0);
        check("ctrl reset", rdv, fpc_pkg::CTRL_RESET);
        ahb(1'b0, 8'h10, 32'h0);
        check("unmapped", rdv, 32'h0);
        setCtrl(32'h3);
        ahb(1'b0, fpc_pkg::ADDR_CTRL, 32'h0);
        check("bad mode", rdv, 32'h0);
        for (int h = 0; h < 8; h++) begin
            setCtrl(32'h402 | (32'(h) << fpc_pkg::CTRL_HYST_LSB));
            check("hysteresis", diffHysteresis, 32'(h));
        end
        check("rx on", diffRxEnable, 32'h1);
        setCtrl(32'h1402);
        check("rx asleep", diffRxEnable, 32'h0);
        setCtrl(32'h3402);
        check("rx wake", diffRxEnable, 32'h1);
        setCtrl(32'h400);
        txCoded(8'ha5);
        xcvr.sendCoded(8'h3c);
        rxCheck(8'h3c);
        modeDiff = 1'b1;
        setCtrl(32'h402);
        txCoded(8'h0f);
        xcvr.sendCoded(8'hc3);
        rxCheck(8'hc3);
        modeDiff = 1'b0;
        setCtrl(32'h401);
        check("special oe", {txOe, ebOe, negOe, frOe}, 32'hd);
        fork
            xcvr.sendRaw(8'h5a);
            ahb(1'b1, fpc_pkg::ADDR_TXDATA, 32'h96);
            begin
                @(posedge frOut);
                for (int i = 0; i < 8; i++) begin
                    @(negedge linkClk);
                    got[i] = txOut;
                    hi[i] = ebOut;
                    @(negedge linkClk);
                    lo[i] = ebOut;
                end
            end
        join
        check("raw tx", got, 32'h96);
        check("bit clock", {hi, lo}, 32'hff00);
        waitIdle();
        rxCheck(8'h5a);
        summarize();
    end
endmodule : test_five_pin_network_comm_port
